// ==== design/ram_power_pkg.sv ====
// constants and types for the ram section power and retention block
//------------------------------------------------------------------
// Contract
// - powered section always keeps its contents
// - unpowered section keeps contents only if retained
// - system off forces every section off
// - upper sixteen bits are retention enables, reset zero
// - control word read/write at 0x930
// - set alias at 0x934 switches sections on
// - bank 2 clear alias at 0x928 clears bits
//------------------------------------------------------------------
package ram_power_pkg;
	localparam int          SECTIONS      = 16;
	localparam int          ADDR_W        = 12;
	localparam int          DATA_W        = 32;
	localparam logic [11:0] BANK2_CTRL_OFF = 12'h920;
	localparam logic [11:0] BANK2_SET_OFF  = 12'h924;
	localparam logic [11:0] BANK2_CLR_OFF  = 12'h928;
	localparam logic [11:0] BANK3_CTRL_OFF = 12'h930;
	localparam logic [11:0] BANK3_SET_OFF  = 12'h934;
	localparam logic [31:0] CTRL_RESET     = 32'h0000FFFF;
	localparam logic [31:0] POWER_MASK     = 32'h0000FFFF;
	localparam logic [31:0] ZERO_WORD      = 32'h00000000;

	// control word split into power and retention halves
	typedef struct packed {
		logic [15:0] keep_contents;
		logic [15:0] keep_on;
	} section_ctrl_type;

	// per-section supply state seen by the ram macros
	typedef struct packed {
		logic [15:0] supply_on;
		logic [15:0] retain;
	} section_drive_type;
endpackage

// ==== design/ram_bank_ctrl.sv ====
// one bank's power control word with set and clear aliases
`timescale 1ns/1ps
`default_nettype none
module ram_bank_ctrl
	import ram_power_pkg::*;
(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// write requests
	input  wire logic             wr_word,
	input  wire logic             wr_set,
	input  wire logic             wr_clr,
	input  wire logic [31:0]      wdata,
	// state
	output section_ctrl_type      ctrl
);
	logic [31:0] ctrl_d;
	logic [31:0] ctrl_q;

	// next value of the control word
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_word) begin
			ctrl_d = wdata;
		end else if (wr_set) begin
			ctrl_d = ctrl_q | (wdata & POWER_MASK);
		end else if (wr_clr) begin
			ctrl_d = ctrl_q & ~wdata;
		end
	end

	// register with power bits on at reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_q <= CTRL_RESET;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	assign ctrl = ctrl_q;
endmodule
`default_nettype wire

// ==== design/ram_section_power_retention.sv ====
// register slave and section supply logic for ram banks 2 and 3
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module ram_section_power_retention
	import ram_power_pkg::*;
(
	// clock and reset
	input  wire logic              I_CLOCK,
	input  wire logic              I_RST_N,
	// register port
	input  wire logic [11:0]       I_ADDR,
	input  wire logic [31:0]       I_WDATA,
	input  wire logic              I_WR,
	input  wire logic              I_RD,
	output logic      [31:0]       O_RDATA,
	// power mode
	input  wire logic              I_SYSTEM_OFF,
	// section drive
	output section_drive_type      O_BANK2_DRIVE,
	output section_drive_type      O_BANK3_DRIVE
);
	section_ctrl_type  bank2_ctrl;
	section_ctrl_type  bank3_ctrl;
	logic              b2_word;
	logic              b2_set;
	logic              b2_clr;
	logic              b3_word;
	logic              b3_set;
	logic [31:0]       rdata_d;
	logic [31:0]       rdata_q;
	section_drive_type b2_drive_d;
	section_drive_type b2_drive_q;
	section_drive_type b3_drive_d;
	section_drive_type b3_drive_q;

	//------------------------------------------------------------
	// address decode
	//------------------------------------------------------------
	// write strobes per register
	always_comb begin
		b2_word = 1'b0;
		b2_set  = 1'b0;
		b2_clr  = 1'b0;
		b3_word = 1'b0;
		b3_set  = 1'b0;
		if (!I_WR) begin
			b2_word = 1'b0;
		end else if (I_ADDR == BANK2_CTRL_OFF) begin
			b2_word = 1'b1;
		end else if (I_ADDR == BANK2_SET_OFF) begin
			b2_set = 1'b1;
		end else if (I_ADDR == BANK2_CLR_OFF) begin
			b2_clr = 1'b1;
		end else if (I_ADDR == BANK3_CTRL_OFF) begin
			b3_word = 1'b1;
		end else if (I_ADDR == BANK3_SET_OFF) begin
			b3_set = 1'b1;
		end
	end

	//------------------------------------------------------------
	// control words
	//------------------------------------------------------------
	ram_bank_ctrl u_bank2 (
		.clk     (I_CLOCK),
		.rst_n   (I_RST_N),
		.wr_word (b2_word),
		.wr_set  (b2_set),
		.wr_clr  (b2_clr),
		.wdata   (I_WDATA),
		.ctrl    (bank2_ctrl)
	);

	ram_bank_ctrl u_bank3 (
		.clk     (I_CLOCK),
		.rst_n   (I_RST_N),
		.wr_word (b3_word),
		.wr_set  (b3_set),
		.wr_clr  (1'b0),
		.wdata   (I_WDATA),
		.ctrl    (bank3_ctrl)
	);

	//------------------------------------------------------------
	// read path
	//------------------------------------------------------------
	// aliases and unmapped offsets read as zero
	always_comb begin
		rdata_d = ZERO_WORD;
		if (!I_RD) begin
			rdata_d = ZERO_WORD;
		end else if (I_ADDR == BANK2_CTRL_OFF) begin
			rdata_d = bank2_ctrl;
		end else if (I_ADDR == BANK3_CTRL_OFF) begin
			rdata_d = bank3_ctrl;
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_N) begin
			rdata_q <= ZERO_WORD;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign O_RDATA = rdata_q;

	//------------------------------------------------------------
	// section supply and retention
	//------------------------------------------------------------
	// supply follows power bits unless system off; retain when on or retention bit set
	always_comb begin
		b2_drive_d.supply_on = I_SYSTEM_OFF ? 16'h0000 : bank2_ctrl.keep_on;
		b3_drive_d.supply_on = I_SYSTEM_OFF ? 16'h0000 : bank3_ctrl.keep_on;
		// powered sections always keep contents, off ones per retention bit
		b2_drive_d.retain = b2_drive_d.supply_on | bank2_ctrl.keep_contents;
		b3_drive_d.retain = b3_drive_d.supply_on | bank3_ctrl.keep_contents;
	end

	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_N) begin
			b2_drive_q <= {CTRL_RESET[15:0], CTRL_RESET[15:0]};
			b3_drive_q <= {CTRL_RESET[15:0], CTRL_RESET[15:0]};
		end else begin
			b2_drive_q <= b2_drive_d;
			b3_drive_q <= b3_drive_d;
		end
	end

	assign O_BANK2_DRIVE = b2_drive_q;
	assign O_BANK3_DRIVE = b3_drive_q;
endmodule
`default_nettype wire

// ==== tb/ram_power_props.sv ====
// port assertions for the ram section power block
`timescale 1ns/1ps
`default_nettype none
module ram_power_props
	import ram_power_pkg::*;
(
	// inputs
	input wire logic              I_CLOCK,
	input wire logic              I_RST_N,
	input wire logic [11:0]       I_ADDR,
	input wire logic [31:0]       I_WDATA,
	input wire logic              I_WR,
	input wire logic              I_RD,
	input wire logic              I_SYSTEM_OFF,
	// outputs
	input wire logic [31:0]       O_RDATA,
	input wire section_drive_type O_BANK2_DRIVE,
	input wire section_drive_type O_BANK3_DRIVE
);
	// write data halves
	logic [15:0] lo, hi;
	assign lo = I_WDATA[15:0];
	assign hi = I_WDATA[31:16];
	default clocking @(posedge I_CLOCK); endclocking
	default disable iff (!I_RST_N);
	rdata_idle_a: assert property (!$past(I_RD) |-> O_RDATA == 32'h0)
		else $error("rdata not idle");
	reset_drive_a: assert property (!$past(I_RST_N) |-> O_BANK3_DRIVE == 32'hFFFFFFFF)
		else $error("reset drive");
	off_forces_a: assert property (I_SYSTEM_OFF |=> O_BANK2_DRIVE.supply_on == 16'h0
		&& O_BANK3_DRIVE.supply_on == 16'h0) else $error("off not forced");
	on_retains_a: assert property ((O_BANK3_DRIVE.supply_on & ~O_BANK3_DRIVE.retain) == 16'h0)
		else $error("on not retained");
	word_drive_a: assert property (I_WR && I_ADDR == 12'h930 ##1 !I_SYSTEM_OFF |=>
		O_BANK3_DRIVE == {$past(lo, 2), $past(lo, 2) | $past(hi, 2)}) else $error("drive");
	set_alias_a: assert property (I_WR && I_ADDR == 12'h934 ##1 !I_SYSTEM_OFF |=>
		(O_BANK3_DRIVE.supply_on & $past(lo, 2)) == $past(lo, 2)) else $error("set");
	clear_alias_a: assert property (I_WR && I_ADDR == 12'h928 ##1 !I_SYSTEM_OFF |=>
		(O_BANK2_DRIVE.supply_on & $past(lo, 2)) == 16'h0) else $error("clear");
	word_readback_a: assert property (I_WR && I_ADDR == 12'h930 ##1 !I_WR ##1
		I_RD && I_ADDR == 12'h930 |=> O_RDATA == $past(I_WDATA, 3)) else $error("readback");
	cover property (I_SYSTEM_OFF);
	cover property (I_WR && I_ADDR == 12'h934);
	cover property (I_WR && I_ADDR == 12'h928);
endmodule
bind ram_section_power_retention ram_power_props ram_power_props_i (.*);
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the ram section power block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        I_CLOCK = 0, I_RST_N = 0, I_WR = 0, I_RD = 0, I_SYSTEM_OFF = 0;
	logic [11:0] I_ADDR = 12'h000;
	logic [31:0] I_WDATA = 32'h0, O_RDATA, b2, b3;
	int          mismatches = 0, tests_run = 0;
	ram_section_power_retention ram_section_power_retention_i (.I_CLOCK(I_CLOCK),
		.I_RST_N(I_RST_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
		.O_RDATA(O_RDATA), .I_SYSTEM_OFF(I_SYSTEM_OFF), .O_BANK2_DRIVE(b2), .O_BANK3_DRIVE(b3));
	always #2.5 I_CLOCK = ~I_CLOCK;
	// compare and bus tasks
	task check(input string n, input logic [31:0] s, e);
		tests_run++;
		if (s !== e) begin
			mismatches++;
			$display("CHECK FAILED %s exp %h seen %h", n, e, s);
		end
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge I_CLOCK);
		I_WR <= 1'h1;
		I_ADDR <= a;
		I_WDATA <= d;
		@(posedge I_CLOCK);
		I_WR <= 1'h0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge I_CLOCK);
		I_RD <= 1'h1;
		I_ADDR <= a;
		@(posedge I_CLOCK);
		I_RD <= 1'h0;
		#1 check("rdata", O_RDATA, e);
	endtask
	task dr(input logic [31:0] e2, e3);
		repeat (2) @(posedge I_CLOCK);
		#1 check("bank2", b2, e2);
		check("bank3", b3, e3);
	endtask
	// scenarios
	task t_reset;
		rd(12'h930, 32'h0000FFFF);
		dr(32'hFFFFFFFF, 32'hFFFFFFFF);
	endtask
	task t_word;
		wr(12'h930, 32'hA5A50F0F);
		rd(12'h930, 32'hA5A50F0F);
		dr(32'hFFFFFFFF, 32'h0F0FAFAF);
	endtask
	task t_set;
		wr(12'h934, 32'hFFFF00F0);
		rd(12'h930, 32'hA5A50FFF);
		rd(12'h934, 32'h0);
	endtask
	task t_clear;
		wr(12'h920, 32'hFFFFFFFF);
		wr(12'h928, 32'h80010003);
		rd(12'h920, 32'h7FFEFFFC);
		dr(32'hFFFCFFFE, 32'h0FFFAFFF);
	endtask
	task t_off;
		@(posedge I_CLOCK);
		I_SYSTEM_OFF <= 1'h1;
		dr(32'h00007FFE, 32'h0000A5A5);
		@(posedge I_CLOCK);
		I_SYSTEM_OFF <= 1'h0;
		rd(12'h938, 32'h0);
	endtask
	// verdict and end of run
	task end_of_test;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// watchdog
	initial begin
		#5000;
		mismatches++;
		end_of_test;
	end
	// main sequence
	initial begin
		repeat (20) @(posedge I_CLOCK);
		I_RST_N <= 1'h1;
		t_reset;
		t_word;
		t_set;
		t_clear;
		t_off;
		end_of_test;
	end
endmodule
`default_nettype wire
